// >>> src/lir_pkg.sv
// Package: addresses, field positions, reset values and timing counts
`default_nettype none
package lir_pkg;
   localparam logic [7:0] LIR_ADDR_MASTER_AUX = 8'h0E;
   localparam logic [7:0] LIR_ADDR_PORT_PAIR = 8'h10;
   localparam logic [7:0] LIR_RESET_MASTER_AUX = 8'h00;
   localparam logic [7:0] LIR_RESET_PORT_PAIR = 8'h00;
   localparam logic [7:0] LIR_READ_UNMAPPED = 8'h00;
   localparam int LIR_HI_MSB = 7;
   localparam int LIR_HI_LSB = 4;
   localparam int LIR_LO_MSB = 3;
   localparam int LIR_LO_LSB = 0;
   localparam logic LIR_CMD_WRITE = 1'b0;
   localparam logic LIR_CMD_READ = 1'b1;
   localparam logic [3:0] LIR_CODE_OFF = 4'h0;
   localparam logic [3:0] LIR_CODE_STATIC = 4'hF;
   localparam logic [3:0] LIR_LAST_SLOT = 4'hE;
   localparam logic [3:0] LIR_LAST_SUB = 4'hF;
   // Internal oscillator tick: one enable pulse every this many sys_clk cycles
   localparam logic [7:0] LIR_TICK_DIV = 8'h04;
endpackage
`default_nettype wire

// >>> src/lir_timebase.sv
// Gated oscillator tick and master-window slot / sub-slot counters
`default_nettype none
module lir_timebase
   import lir_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic run,
   output logic [3:0] slot,
   output logic [3:0] sub
);
   typedef struct packed
   {
      logic [7:0] div;
      logic [3:0] slot;
      logic [3:0] sub;
   } lir_tb_state_t;

   lir_tb_state_t st_r;
   lir_tb_state_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (!run)
      begin
         // Stopped oscillator restarts at the window start
         st_nxt = '0;
      end
      else if (st_r.div == LIR_TICK_DIV - 8'h01)
      begin
         st_nxt.div = 8'h00;
         if (st_r.sub == LIR_LAST_SUB)
         begin
            st_nxt.sub = 4'h0;
            st_nxt.slot = (st_r.slot == LIR_LAST_SLOT) ? 4'h0 : st_r.slot + 4'h1;
         end
         else
         begin
            st_nxt.sub = st_r.sub + 4'h1;
         end
      end
      else
      begin
         st_nxt.div = st_r.div + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign slot = st_r.slot;
   assign sub = st_r.sub;
endmodule
`default_nettype wire

// >>> src/lir_intensity.sv
// Intensity registers and PWM drive for the auxiliary output and ports zero and one
//
// Overview of operation
// - Master code zero: oscillator stopped, outputs static
// - Master codes 1..15 give code/15 duty
// - Shared register: master bits 7:4, auxiliary 3:0
// - Shared register at 0x0E, written and read back
// - Auxiliary codes 0..14 give (code+1)/16 duty
// - Auxiliary code 15 drives static level
// - Pair register: port one 7:4, zero 3:0
// - Port one codes 0..14 give (code+1)/16
// - Port one code 15 static; register at 0x10
// - Port zero same encoding, 15 static
`default_nettype none
module lir_intensity
   import lir_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire logic cmd_rw,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic osc_running,
   output logic auxiliary_output_on,
   output logic port_zero_on,
   output logic port_one_on
);
   // ***********************************
   // Types and state
   // ***********************************
   typedef struct packed
   {
      logic [7:0] master_aux;
      logic [7:0] port_pair;
      logic [7:0] rd_data;
      logic rd_valid;
      logic osc_running;
      logic aux_on;
      logic p0_on;
      logic p1_on;
   } lir_state_t;

   // Which register a command addresses
   typedef enum logic [1:0]
   {
      LIR_SEL_NONE,
      LIR_SEL_MASTER_AUX,
      LIR_SEL_PORT_PAIR
   } lir_sel_t;

   lir_state_t st_r;
   lir_state_t st_nxt;
   logic [3:0] master_level;
   logic [3:0] slot;
   logic [3:0] sub;
   lir_sel_t cmd_sel;

   // ***********************************
   // Helper functions
   // ***********************************
   // Upper and lower intensity nibbles of a register byte
   function automatic logic [3:0] lir_hi(input logic [7:0] b);
      return b[LIR_HI_MSB:LIR_HI_LSB];
   endfunction

   function automatic logic [3:0] lir_lo(input logic [7:0] b);
      return b[LIR_LO_MSB:LIR_LO_LSB];
   endfunction

   // One decoder shared by write and read keeps both maps identical
   function automatic lir_sel_t lir_decode(input logic [7:0] addr);
      lir_sel_t sel;
      sel = LIR_SEL_NONE;
      if (addr == LIR_ADDR_MASTER_AUX)
      begin
         sel = LIR_SEL_MASTER_AUX;
      end
      else if (addr == LIR_ADDR_PORT_PAIR)
      begin
         sel = LIR_SEL_PORT_PAIR;
      end
      return sel;
   endfunction

   // Read-back mux; addresses owned by other blocks answer a fixed value
   function automatic logic [7:0] lir_read(input lir_sel_t sel, input logic [7:0] master_aux,
                                           input logic [7:0] port_pair);
      logic [7:0] data;
      data = LIR_READ_UNMAPPED;
      unique case (sel)
         LIR_SEL_MASTER_AUX:
         begin
            data = master_aux;
         end
         LIR_SEL_PORT_PAIR:
         begin
            data = port_pair;
         end
         LIR_SEL_NONE:
         begin
            data = LIR_READ_UNMAPPED;
         end
         default:
         begin
            data = LIR_READ_UNMAPPED;
         end
      endcase
      return data;
   endfunction

   // Output on when inside both the master share and the nibble share
   function automatic logic lir_on(input logic [3:0] master, input logic [3:0] code,
                                   input logic [3:0] slot_i, input logic [3:0] sub_i);
      logic on;
      on = 1'b0;
      if (code == LIR_CODE_STATIC)
      begin
         on = 1'b1;
      end
      else if (master == LIR_CODE_OFF)
      begin
         on = 1'b0;
      end
      else
      begin
         // Slots 0..14 form the window, so master 15 fills it
         on = (slot_i < master) && (sub_i <= code);
      end
      return on;
   endfunction

   // ***********************************
   // Oscillator timebase
   // ***********************************
   assign master_level = lir_hi(st_r.master_aux);
   assign cmd_sel = lir_decode(cmd_addr);

   lir_timebase u_timebase
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .run(master_level != LIR_CODE_OFF),
      .slot(slot),
      .sub(sub)
   );

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rd_valid = 1'b0;
      // ***********************************
      // Command decode
      // ***********************************
      if (cmd_valid && cmd_rw == LIR_CMD_WRITE)
      begin
         unique case (cmd_sel)
            LIR_SEL_MASTER_AUX:
            begin
               st_nxt.master_aux = cmd_wdata;
            end
            LIR_SEL_PORT_PAIR:
            begin
               st_nxt.port_pair = cmd_wdata;
            end
            LIR_SEL_NONE:
            begin
               // Writes to other blocks' registers leave ours alone
               st_nxt.master_aux = st_r.master_aux;
            end
            default:
            begin
               st_nxt.master_aux = st_r.master_aux;
            end
         endcase
      end
      else if (cmd_valid && cmd_rw == LIR_CMD_READ)
      begin
         st_nxt.rd_valid = 1'b1;
         st_nxt.rd_data = lir_read(cmd_sel, st_r.master_aux, st_r.port_pair);
      end
      // ***********************************
      // Output drive
      // ***********************************
      st_nxt.osc_running = (master_level != LIR_CODE_OFF);
      st_nxt.aux_on = lir_on(master_level, lir_lo(st_r.master_aux), slot, sub);
      st_nxt.p1_on = lir_on(master_level, lir_hi(st_r.port_pair), slot, sub);
      st_nxt.p0_on = lir_on(master_level, lir_lo(st_r.port_pair), slot, sub);
   end

   // ***********************************
   // State register
   // ***********************************
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= '0;
         st_r.master_aux <= LIR_RESET_MASTER_AUX;
         st_r.port_pair <= LIR_RESET_PORT_PAIR;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ***********************************
   // Output ports
   // ***********************************
   assign rd_data = st_r.rd_data;
   assign rd_valid = st_r.rd_valid;
   assign osc_running = st_r.osc_running;
   assign auxiliary_output_on = st_r.aux_on;
   assign port_zero_on = st_r.p0_on;
   assign port_one_on = st_r.p1_on;
endmodule
`default_nettype wire

// >>> verif/lir_props.sv
// Checker for register access and output levels
`default_nettype none
module lir_props
   import lir_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire logic cmd_rw,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic osc_running,
   input wire logic auxiliary_output_on,
   input wire logic port_zero_on,
   input wire logic port_one_on
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic [7:0] ma_r;
   logic [7:0] pp_r;
   wire logic rd = cmd_valid && cmd_rw;
   wire logic [7:0] exp_rd = cmd_addr == LIR_ADDR_MASTER_AUX ? ma_r : cmd_addr == LIR_ADDR_PORT_PAIR ? pp_r : 8'h00;
   // Shadow copy, updated on the same edge as the real registers
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ma_r <= LIR_RESET_MASTER_AUX;
         pp_r <= LIR_RESET_PORT_PAIR;
      end
      else if (cmd_valid && !cmd_rw)
      begin
         if (cmd_addr == LIR_ADDR_MASTER_AUX) ma_r <= cmd_wdata;
         if (cmd_addr == LIR_ADDR_PORT_PAIR) pp_r <= cmd_wdata;
      end
   end
   a_read_answer: assert property (rd |=> rd_valid) else $error("read not answered");
   a_no_answer: assert property (!rd |=> !rd_valid) else $error("answer without read");
   a_read_data: assert property (rd |=> rd_data == $past(exp_rd)) else $error("read data wrong");
   a_osc_off: assert property ((ma_r[7:4] == 4'h0) [*3] |-> !osc_running) else $error("oscillator runs");
   a_osc_on: assert property ((ma_r[7:4] != 4'h0) [*3] |-> osc_running) else $error("oscillator stopped");
   a_aux_static: assert property ((ma_r[3:0] == 4'hF) [*3] |-> auxiliary_output_on) else $error("aux not static");
   a_one_static: assert property ((pp_r[7:4] == 4'hF) [*3] |-> port_one_on) else $error("port one not static");
   a_zero_static: assert property ((pp_r[3:0] == 4'hF) [*3] |-> port_zero_on) else $error("port zero not static");
endmodule
bind lir_intensity lir_props lir_props_i (.sys_clk, .nrst, .cmd_valid, .cmd_rw, .cmd_addr, .cmd_wdata, .rd_data,
   .rd_valid, .osc_running, .auxiliary_output_on, .port_zero_on, .port_one_on);
`default_nettype wire

// >>> verif/lir_host.sv
// Host model issuing register commands
`default_nettype none
module lir_host
(
   input wire logic sys_clk,
   output logic cmd_valid,
   output logic cmd_rw,
   output logic [7:0] cmd_addr,
   output logic [7:0] cmd_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cmd_valid, cmd_rw, cmd_addr, cmd_wdata} = 18'h0;
   task automatic xfer(input logic rw, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_rw = rw;
      cmd_addr = a;
      cmd_wdata = d;
   endtask
   // Released address and data lines show a changing pattern, not the last value; cmd_rw keeps its last value
   task automatic idle();
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      cmd_addr = ~cmd_addr;
      cmd_wdata = ~cmd_wdata;
   endtask
endmodule
`default_nettype wire

// >>> verif/lir_intensity_tb.sv
// Testbench for the intensity registers and PWM outputs
`default_nettype none
module lir_intensity_tb;
   import lir_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic cmd_valid, cmd_rw, rd_valid, osc_running, auxiliary_output_on, port_zero_on, port_one_on;
   logic [7:0] cmd_addr, cmd_wdata, rd_data;
   int err_total = 0;
   int n_tests = 0;
   logic [31:0] sd = 32'hF87862EC;
   lir_host lir_host_i (.sys_clk, .cmd_valid, .cmd_rw, .cmd_addr, .cmd_wdata);
   lir_intensity lir_intensity_i (.sys_clk, .nrst, .cmd_valid, .cmd_rw, .cmd_addr, .cmd_wdata, .rd_data,
      .rd_valid, .osc_running, .auxiliary_output_on, .port_zero_on, .port_one_on);
   initial forever #2 sys_clk = ~sys_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // On-cycles per 960-cycle window
   function automatic logic [11:0] duty(input logic [3:0] m, input logic [3:0] c);
      return c == LIR_CODE_STATIC ? 12'h3C0 : 12'(int'(m) * (int'(c) + 1) * 4);
   endfunction
   task automatic chk(input string w, input logic [11:0] e, input logic [11:0] g);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", w, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      lir_host_i.xfer(LIR_CMD_READ, a, 8'h00);
      lir_host_i.idle();
      chk("rd_valid", 12'h001, {11'h000, rd_valid});
      chk("rd_data", {4'h0, e}, {4'h0, rd_data});
      @(negedge sys_clk);
      chk("rd_valid_end", 12'h000, {11'h000, rd_valid});
      chk("rd_data_hold", {4'h0, e}, {4'h0, rd_data});
   endtask
   task automatic run(input logic [7:0] ma, input logic [7:0] pp);
      logic [11:0] na, n0, n1;
      lir_host_i.xfer(LIR_CMD_WRITE, LIR_ADDR_MASTER_AUX, ma);
      lir_host_i.xfer(LIR_CMD_WRITE, LIR_ADDR_PORT_PAIR, pp);
      lir_host_i.idle();
      repeat (20) @(negedge sys_clk);
      {na, n0, n1} = 36'h0;
      repeat (960)
      begin
         @(negedge sys_clk);
         na += auxiliary_output_on;
         n0 += port_zero_on;
         n1 += port_one_on;
      end
      chk("aux_duty", duty(ma[7:4], ma[3:0]), na);
      chk("p0_duty", duty(ma[7:4], pp[3:0]), n0);
      chk("p1_duty", duty(ma[7:4], pp[7:4]), n1);
      chk("osc_running", {11'h000, ma[7:4] != LIR_CODE_OFF}, {11'h000, osc_running});
      $display("duty test %0h %0h done", ma, pp);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(negedge sys_clk);
      nrst = 1'b1;
      rd(LIR_ADDR_MASTER_AUX, LIR_RESET_MASTER_AUX);
      rd(LIR_ADDR_PORT_PAIR, LIR_RESET_PORT_PAIR);
      for (int i = 0; i < 8; i++)
      begin
         sd = lfsr(sd);
         lir_host_i.xfer(LIR_CMD_WRITE, LIR_ADDR_MASTER_AUX, sd[23:16]);
         lir_host_i.xfer(LIR_CMD_WRITE, LIR_ADDR_PORT_PAIR, sd[31:24]);
         lir_host_i.xfer(LIR_CMD_WRITE, sd[15:8] | 8'h20, sd[7:0]);
         rd(LIR_ADDR_MASTER_AUX, sd[23:16]);
         rd(LIR_ADDR_PORT_PAIR, sd[31:24]);
         rd(sd[15:8] | 8'h20, LIR_READ_UNMAPPED);
      end
      $display("register test done");
      run(8'h00, 8'h0F);
      run(8'hFE, 8'hE0);
      run(8'h1F, 8'h7F);
      repeat (3)
      begin
         sd = lfsr(sd);
         run(sd[7:0], sd[15:8]);
      end
      // Second reset in mid-run must clear both registers and stop the oscillator
      nrst = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("osc_in_reset", 12'h000, {11'h000, osc_running});
      nrst = 1'b1;
      rd(LIR_ADDR_MASTER_AUX, LIR_RESET_MASTER_AUX);
      rd(LIR_ADDR_PORT_PAIR, LIR_RESET_PORT_PAIR);
      $display("reset test done");
      give_verdict();
   end
   initial
   begin
      #100us;
      err_total++;
      give_verdict();
   end
endmodule
`default_nettype wire
